// [pkg/pcrs_pkg.sv]
// shared constants for the fetch pointer and return stack block
package pcrs_pkg;
    localparam int PCRS_PC_W       = 21;              // fetch pointer width
    localparam int PCRS_SP_W       = 5;               // stack pointer width
    localparam int PCRS_DEPTH      = 31;              // stack entries
    localparam logic [20:0] PCRS_PC_RST   = 21'h000000;
    localparam logic [4:0]  PCRS_SP_RST   = 5'h00;
    localparam logic [4:0]  PCRS_SP_FULL  = 5'h1f;
    localparam logic [20:0] PCRS_PC_STEP  = 21'h000002; // one instruction word
    localparam logic [20:0] PCRS_VEC_HIGH = 21'h000008; // high priority vector
    localparam logic [20:0] PCRS_VEC_LOW  = 21'h000018; // low priority vector
    localparam int PCRS_LOW_LSB    = 0;               // forced-zero bit
    localparam int PCRS_HIGH_LSB   = 8;               // high byte position
    localparam int PCRS_UPPER_LSB  = 16;              // upper byte position
    localparam int PCRS_UPPER_W    = 5;               // upper byte width
endpackage : pcrs_pkg

// [design/pcrs_stack_ram.sv]
// return stack storage: 31 entries, entry 0 has no storage behind it
`timescale 1ns/1ns
module pcrs_stack_ram
    import pcrs_pkg::*;
#(
    parameter int DEPTH = PCRS_DEPTH,
    parameter int AW    = PCRS_SP_W,
    parameter int DW    = PCRS_PC_W
) (
    input  wire logic          clk,     // core clock
    input  wire logic          wr_en,   // write strobe
    input  wire logic [AW-1:0] wr_addr, // write index
    input  wire logic [DW-1:0] wr_data, // value written
    input  wire logic [AW-1:0] rd_addr, // read index
    output logic      [DW-1:0] rd_data  // value at read index, zero at 0
);
    logic [DW-1:0] mem [1:DEPTH];

    // index zero is only a reset value, so writes there are dropped
    always_ff @(posedge clk) begin
        if (wr_en && wr_addr != '0) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = (rd_addr == '0) ? '0 : mem[rd_addr];
endmodule : pcrs_stack_ram

// [design/pcrs_core.sv]
// fetch pointer, byte latches and hardware return stack of the core
//
// Overview of operation
// - fetch pointer is 21 bits over low, high and upper bytes
// - low byte read/write; high byte changes only via its latch
// - upper byte bits 20:16 change only via its latch
// - writing the low byte loads both latches into the pointer
// - reading the low byte copies high and upper bytes into latches
// - bit 0 of the fetch pointer is always zero
// - pointer is a byte address, advancing by two per instruction
// - jumps, calls and branches load pointer directly, no latch transfer
// - stack is 31 entries of 21 bits with a 5-bit pointer
// - push on call, relative call, interrupt; pop on the three returns
// - with extended set, add/subtract-and-unlink also pop
// - calls and returns leave both latches unchanged
// - push increments pointer then writes address of next instruction on a call, current pointer on an interrupt
// - pop loads pointer from top entry, then decrements
// - stack pointer zero after reset, entry zero has no storage
// - status shows stack full, overflow and underflow
// - software reads and writes stack pointer and top entry
// - only the addressed entry is visible as upper, high, low bytes
// - interrupt wake with an enable set pushes and loads the vector
`timescale 1ns/1ns
module pcrs_core
    import pcrs_pkg::*;
#(
    parameter int PC_W  = PCRS_PC_W,
    parameter int SP_W  = PCRS_SP_W,
    parameter int DEPTH = PCRS_DEPTH
) (
    input  wire logic            clk,             // core clock, 20 MHz
    input  wire logic            rst_b,           // async reset, active low
    // sequencer commands, one-cycle strobes
    input  wire logic            advance,         // sequential instruction
    input  wire logic            direct_load,     // jump, call or branch
    input  wire logic [PC_W-1:0] direct_target,   // target of direct load
    input  wire logic            call_push,       // call or relative call
    input  wire logic            irq_ack,         // interrupt acknowledge
    input  wire logic            irq_high,        // 1 high vector, 0 low
    input  wire logic            wake_irq,        // wake-up by interrupt
    input  wire logic            low_priority_global_enable,  // enable low
    input  wire logic            high_priority_global_enable, // enable high
    input  wire logic            ret_pop,         // return / literal / irq
    input  wire logic            unlink_pop,      // add or subtract unlink
    input  wire logic            ext_set_en,      // extended set enabled
    // special function register access, one-cycle strobes
    input  wire logic            low_byte_wr,     // write low byte
    input  wire logic            low_byte_rd,     // read low byte
    input  wire logic            high_latch_wr,   // write high latch
    input  wire logic            upper_latch_wr,  // write upper latch
    input  wire logic            sp_wr,           // write stack pointer
    input  wire logic            tos_upper_wr,    // write top upper byte
    input  wire logic            tos_high_wr,     // write top high byte
    input  wire logic            tos_low_wr,      // write top low byte
    input  wire logic            flag_clr,        // clear sticky flags
    input  wire logic [7:0]      wr_data,         // byte being written
    // state shown to software and sequencer
    output logic [PC_W-1:0]      instr_fetch_pointer,    // fetch address
    output logic [7:0]           fetch_pointer_low_byte, // readable low byte
    output logic [7:0]           high_byte_latch,        // high latch
    output logic [7:0]           upper_byte_latch,       // upper latch
    output logic [SP_W-1:0]      return_stack_pointer,   // stack pointer
    output logic [7:0]           top_entry_upper_byte,   // top bits 20:16
    output logic [7:0]           top_entry_high_byte,    // top bits 15:8
    output logic [7:0]           top_entry_low_byte,     // top bits 7:0
    output logic                 stack_full,             // pointer at 31
    output logic                 stack_overflow,         // sticky overflow
    output logic                 stack_underflow         // sticky underflow
);
    // machine state kept only to show which kind of step happened last
    typedef enum logic [3:0] {
        PCRS_IDLE = 4'b0001,
        PCRS_PUSH = 4'b0010,
        PCRS_POP  = 4'b0100,
        PCRS_LOAD = 4'b1000
    } pcrs_step_e;

    pcrs_step_e      step;
    pcrs_step_e      next_step;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic [7:0]      lat_high;
    logic [7:0]      lat_upper;
    logic [SP_W-1:0] sp;
    logic [SP_W-1:0] next_sp;
    logic            ovf;
    logic            unf;
    logic [PC_W-1:0] top_stack_entry;

    // command decode
    wire wake_vec   = wake_irq &&
        (low_priority_global_enable || high_priority_global_enable);
    wire push_req   = call_push || irq_ack || wake_vec;
    wire pop_req    = ret_pop || (unlink_pop && ext_set_en);
    wire at_full    = (sp == PCRS_SP_FULL);
    wire at_empty   = (sp == PCRS_SP_RST);
    wire push_ok    = push_req && !at_full;
    wire pop_ok     = pop_req && !at_empty;
    wire [PC_W-1:0] next_instr = pc + PCRS_PC_STEP;
    wire [PC_W-1:0] vector     = irq_high ? PCRS_VEC_HIGH : PCRS_VEC_LOW;
    wire [SP_W-1:0] sp_inc     = sp + 5'h01;
    wire [SP_W-1:0] sp_dec     = sp - 5'h01;

    // latch contents assembled as a full pointer for a low byte write
    wire [PC_W-1:0] latched_pc = {lat_upper[PCRS_UPPER_W-1:0], lat_high,
                                  wr_data};

    // top entry write: merge one byte into the addressed entry
    wire tos_wr = tos_upper_wr || tos_high_wr || tos_low_wr;
    wire [PC_W-1:0] tos_merged = {
        tos_upper_wr ? wr_data[PCRS_UPPER_W-1:0]
                     : top_stack_entry[PC_W-1:PCRS_UPPER_LSB],
        tos_high_wr  ? wr_data : top_stack_entry[PCRS_UPPER_LSB-1:PCRS_HIGH_LSB],
        tos_low_wr   ? wr_data : top_stack_entry[PCRS_HIGH_LSB-1:0]};

    // stack write port: a push stores the return address at sp+1
    // software byte writes lose to any push or pop in the same cycle
    wire            ram_we    = push_ok
                              || (tos_wr && !push_req && !pop_req);
    wire [SP_W-1:0] ram_waddr = push_ok ? sp_inc : sp;
    wire [PC_W-1:0] ram_wdata = push_ok ? (call_push ? next_instr : pc)
                                        : tos_merged;

    pcrs_stack_ram #(
        .DEPTH (DEPTH),
        .AW    (SP_W),
        .DW    (PC_W)
    ) u_ram (
        .clk     (clk),
        .wr_en   (ram_we),
        .wr_addr (ram_waddr),
        .wr_data (ram_wdata),
        .rd_addr (sp),
        .rd_data (top_stack_entry)
    );

    // next fetch pointer and step, priority: pop, push, direct, low write
    always_comb begin
        next_pc   = pc;
        next_step = PCRS_IDLE;
        if (pop_req) begin
            next_pc   = pop_ok ? top_stack_entry : PCRS_PC_RST;
            next_step = PCRS_POP;
        end else if (push_req) begin
            next_pc   = (irq_ack || wake_vec) ? vector : direct_target;
            next_step = PCRS_PUSH;
        end else if (direct_load) begin
            next_pc   = direct_target;
            next_step = PCRS_LOAD;
        end else if (low_byte_wr) begin
            next_pc   = latched_pc;
            next_step = PCRS_LOAD;
        end else if (advance) begin
            next_pc   = next_instr;
        end
        next_pc[PCRS_LOW_LSB] = 1'b0;
    end

    // next stack pointer: software write loses to hardware push or pop
    always_comb begin
        next_sp = sp;
        case (1'b1)
            push_ok: next_sp = sp_inc;
            pop_ok:  next_sp = sp_dec;
            sp_wr && !push_req && !pop_req:
                     next_sp = wr_data[SP_W-1:0];
            default: next_sp = sp;
        endcase
    end

    // fetch pointer, pointer and step registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc   <= PCRS_PC_RST;
            sp   <= PCRS_SP_RST;
            step <= PCRS_IDLE;
        end else begin
            pc   <= next_pc;
            sp   <= next_sp;
            step <= next_step;
        end
    end

    // latches: calls and returns never touch them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lat_high  <= 8'h00;
            lat_upper <= 8'h00;
        end else if (low_byte_rd) begin
            lat_high  <= pc[PCRS_UPPER_LSB-1:PCRS_HIGH_LSB];
            lat_upper <= {3'h0, pc[PC_W-1:PCRS_UPPER_LSB]};
        end else begin
            if (high_latch_wr) begin
                lat_high <= wr_data;
            end
            if (upper_latch_wr) begin
                lat_upper <= wr_data;
            end
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ovf <= 1'b0;
            unf <= 1'b0;
        end else begin
            ovf <= (push_req && at_full) || (ovf && !flag_clr);
            unf <= (pop_req && at_empty) || (unf && !flag_clr);
        end
    end

    // software sees the pointer and top entry through byte views
    assign instr_fetch_pointer    = pc;
    assign fetch_pointer_low_byte = pc[PCRS_HIGH_LSB-1:0];
    assign high_byte_latch        = lat_high;
    assign upper_byte_latch       = lat_upper;
    assign return_stack_pointer   = sp;
    assign top_entry_upper_byte   = {3'h0, top_stack_entry[PC_W-1:PCRS_UPPER_LSB]};
    assign top_entry_high_byte    = top_stack_entry[PCRS_UPPER_LSB-1:PCRS_HIGH_LSB];
    assign top_entry_low_byte     = top_stack_entry[PCRS_HIGH_LSB-1:0];
    assign stack_full             = at_full;
    assign stack_overflow         = ovf;
    assign stack_underflow        = unf;
    // note: software must mask interrupts around stack edits
endmodule : pcrs_core

// [bench/pcrs_checker.sv]
// port-level assertions for the fetch pointer and return stack
`timescale 1ns/1ns
module pcrs_checker #(parameter int PC_W = 21, parameter int SP_W = 5) (
    input wire logic clk, rst_b, advance, direct_load, call_push, irq_ack,
    input wire logic wake_irq, ret_pop, unlink_pop, ext_set_en,
    input wire logic low_byte_wr, low_byte_rd,
    input wire logic [PC_W-1:0] instr_fetch_pointer,
    input wire logic [7:0] wr_data, high_byte_latch, upper_byte_latch,
    input wire logic [7:0] top_entry_upper_byte, top_entry_high_byte,
    input wire logic [7:0] top_entry_low_byte,
    input wire logic [SP_W-1:0] return_stack_pointer,
    input wire logic stack_full, stack_underflow
);
    // wake counted as busy: it may push, so it masks the simple cases
    wire logic pop_any = ret_pop | (unlink_pop & ext_set_en);
    wire logic pc_busy = pop_any | call_push | irq_ack | wake_irq
                         | direct_load;
    wire logic [PC_W-1:0] top = {top_entry_upper_byte[4:0],
                                 top_entry_high_byte, top_entry_low_byte};
    wire logic [12:0] latched = {upper_byte_latch[4:0], high_byte_latch};
    wire logic [12:0] pc_hi = instr_fetch_pointer[20:8];

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_reset_clear:
        assert property ($rose(rst_b) |-> return_stack_pointer == 5'h00)
        else $error("stack pointer not zero after reset");
    a_word_aligned:
        assert property (instr_fetch_pointer[0] == 1'b0)
        else $error("fetch pointer odd");
    a_full_level:
        assert property (stack_full == (return_stack_pointer == 5'h1f))
        else $error("full flag wrong");
    a_advance_two:
        assert property (advance && !pc_busy && !low_byte_wr |=>
            instr_fetch_pointer == $past(instr_fetch_pointer) + 21'h000002)
        else $error("advance not by two");
    a_low_write:
        assert property (low_byte_wr && !pc_busy |=> instr_fetch_pointer
            == {$past(latched), $past(wr_data) & 8'hfe})
        else $error("low byte write did not load latches");
    a_low_read:
        assert property (low_byte_rd |=>
            {upper_byte_latch[4:0], high_byte_latch} == $past(pc_hi))
        else $error("low byte read did not fill latches");
    a_push_order:
        assert property (call_push && !pop_any &&
            return_stack_pointer != 5'h1f |=>
            return_stack_pointer == $past(return_stack_pointer) + 5'h01
            && top == $past(instr_fetch_pointer) + 21'h000002)
        else $error("push wrong");
    a_pop_order:
        assert property (ret_pop && return_stack_pointer != 5'h00 |=>
            instr_fetch_pointer == ($past(top) & 21'h1ffffe)
            && return_stack_pointer == $past(return_stack_pointer) - 5'h01)
        else $error("pop wrong");
    a_pop_empty:
        assert property (ret_pop && return_stack_pointer == 5'h00 |=>
            stack_underflow && instr_fetch_pointer == 21'h000000)
        else $error("empty pop wrong");
endmodule : pcrs_checker

bind pcrs_core pcrs_checker #(.PC_W(PC_W), .SP_W(SP_W)) u_chk (.*);

// [bench/pcrs_seq_model.sv]
// sequencer model: turns a command code into one-cycle strobes
`timescale 1ns/1ns
module pcrs_seq_model (
    input  wire logic        go,      // issue command this cycle
    input  wire logic [3:0]  op,      // command code
    input  wire logic        ints_on, // software wants interrupts on
    output logic      [15:0] strb,    // one-hot command strobes
    output logic             gie      // both global enables
);
    // one strobe at a time; bench holds go from fall to fall
    assign strb = go ? (16'h0001 << op) : 16'h0000;
    // enables dropped while stack registers are written
    assign gie = ints_on & ~(go & (op >= 4'hb) & (op <= 4'he));
endmodule : pcrs_seq_model

// [bench/tb.sv]
// self-checking bench for the fetch pointer and return stack
`timescale 1ns/1ns
module tb;
    logic        clk, rst_b, go, ints_on, irq_high, ext_set_en, gie;
    logic        full, ovf, unf;
    logic [3:0]  op;
    logic [4:0]  sp;
    logic [7:0]  wr_data, hl, ul, tu, th, tl, lb;
    logic [15:0] strb;
    logic [20:0] tgt, pc;
    int          n_mismatch, tests_run;
    wire logic [20:0] top = {tu[4:0], th, tl};
    wire logic [20:0] lat = {5'h00, ul, hl};
    wire logic [20:0] spx = {16'h0000, sp};

    pcrs_seq_model seq (.go(go), .op(op), .ints_on(ints_on), .strb(strb),
        .gie(gie));
    pcrs_core uut (.clk(clk), .rst_b(rst_b), .advance(strb[0]),
        .direct_load(strb[1]), .direct_target(tgt), .call_push(strb[2]),
        .irq_ack(strb[3]), .irq_high(irq_high), .wake_irq(strb[4]),
        .low_priority_global_enable(gie), .high_priority_global_enable(gie),
        .ret_pop(strb[5]), .unlink_pop(strb[6]), .ext_set_en(ext_set_en),
        .low_byte_wr(strb[7]), .low_byte_rd(strb[8]),
        .high_latch_wr(strb[9]), .upper_latch_wr(strb[10]),
        .sp_wr(strb[11]), .tos_upper_wr(strb[12]), .tos_high_wr(strb[13]),
        .tos_low_wr(strb[14]), .flag_clr(strb[15]), .wr_data(wr_data),
        .instr_fetch_pointer(pc), .fetch_pointer_low_byte(lb),
        .high_byte_latch(hl), .upper_byte_latch(ul),
        .return_stack_pointer(sp), .top_entry_upper_byte(tu),
        .top_entry_high_byte(th), .top_entry_low_byte(tl),
        .stack_full(full), .stack_overflow(ovf), .stack_underflow(unf));

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one command, strobe high for exactly one rising edge
    task automatic cmd(input logic [3:0] o, input logic [7:0] d);
        @(negedge clk);
        op = o;
        wr_data = d;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
    endtask : cmd
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic t_seq;
        chk(pc | spx, 21'h000000);
        cmd(4'h0, 8'h00);
        cmd(4'h0, 8'h00);
        chk(pc, 21'h000004);
        cmd(4'h9, 8'h45);
        cmd(4'ha, 8'he3);
        cmd(4'h7, 8'h67);
        chk(pc, 21'h034566);
        chk({13'h0000, lb}, 21'h000066);
        tgt = 21'h1abcd;
        cmd(4'h1, 8'h00);
        chk(pc, 21'h1abcc);
        chk(lat, 21'h00e345);
        cmd(4'h8, 8'h00);
        chk(lat, 21'h0001ab);
    endtask : t_seq
    task automatic t_calls;
        tgt = 21'h000100;
        cmd(4'h2, 8'h00);
        chk(top, 21'h01abce);
        irq_high = 1'b1;
        cmd(4'h3, 8'h00);
        chk(top | pc, 21'h000108);
        irq_high = 1'b0;
        cmd(4'h4, 8'h00);
        chk(pc, 21'h000018);
        ints_on = 1'b0;
        cmd(4'h4, 8'h00);
        chk(spx, 21'h000003);
        ints_on = 1'b1;
        chk(lat, 21'h0001ab);
    endtask : t_calls
    task automatic t_returns;
        cmd(4'h5, 8'h00);
        chk(pc, 21'h000008);
        cmd(4'h6, 8'h00);
        chk(spx, 21'h000002);
        ext_set_en = 1'b1;
        cmd(4'h6, 8'h00);
        chk(pc | spx, 21'h000101);
        cmd(4'h5, 8'h00);
        cmd(4'h5, 8'h00);
        chk({pc[19:0], unf}, 21'h000001);
        cmd(4'hf, 8'h00);
        chk({20'h00000, unf}, 21'h000000);
    endtask : t_returns
    task automatic t_full;
        cmd(4'hb, 8'h1f);
        chk({20'h00000, full}, 21'h000001);
        cmd(4'hc, 8'h01);
        cmd(4'hd, 8'h23);
        cmd(4'he, 8'h45);
        chk(top, 21'h012345);
        cmd(4'h2, 8'h00);
        chk({ovf, spx[19:0]}, 21'h10001f);
        chk(top, 21'h012345);
    endtask : t_full

    // free-running core clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard: the run needs far fewer cycles than this
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        {rst_b, go, ints_on, irq_high, ext_set_en} = 5'h04;
        op = 4'h0;
        wr_data = 8'h00;
        tgt = 21'h000000;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        t_seq();
        t_calls();
        t_returns();
        t_full();
        stop_test();
    end
endmodule : tb
